// ===== cmp_analog_model.sv
// Behavioural model of the analog comparator and its reference ladder.
`timescale 1ns/1ps
module cmp_analog_model (
    input  wire cmp_pkg::analog_ctrl_t ctrl_i,
    input  var  int                    pos_mv_i,
    input  var  int                    ext_mv_i,
    output logic                       raw_o
);
    import cmp_pkg::*;
    int neg_mv;
    // Voltage on the negative input in millivolts; external wins over bandgap, bandgap over ladder.
    always_comb begin
        if (ctrl_i.source == REF_EXTERNAL) begin
            neg_mv = ext_mv_i;
        end else if (ctrl_i.source == REF_BANDGAP) begin
            neg_mv = 1200;
        end else begin
            neg_mv = 200 + 200 * int'(ctrl_i.level_code);
        end
    end
    // A powered-down comparator drives low, so the block itself must supply the idle one.
    assign raw_o = ctrl_i.power_on ? (pos_mv_i > neg_mv) : 1'b0;
endmodule

// ===== cmp_consts.svh
// Register offsets, field positions, reset values and timing counts of the comparator control block.
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

`define AXI_ADDR_W      8
`define REF_SEL_INDEX   6'h2c
`define CMP_CTRL_INDEX  6'h2d
`define REF_SEL_RESET   8'h00
`define CMP_CTRL_RESET  8'h80

`define RS_EXT_BIT      7
`define RS_BGR_BIT      6
`define RS_LVL_HI       5
`define RS_LVL_LO       2

`define CC_HYST_BIT     7
`define CC_INV_BIT      5
`define CC_FLAG_BIT     4
`define CC_IEN_BIT      3
`define CC_RES_BIT      2
`define CC_POE_BIT      1
`define CC_PON_BIT      0

`define CLK_PERIOD_NS   20
`define EDGE_DELAY_NS   250
`define EDGE_DELAY_CYC  ((`EDGE_DELAY_NS) / (`CLK_PERIOD_NS))

`define ADC_CH_POS      3'h0
`define ADC_CH_NEG      3'h4

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== cmp_event_delay.sv
// Delays a comparator edge by a fixed number of clock cycles before it reaches the flag.
`timescale 1ns/1ps
module cmp_event_delay #(
    parameter int DELAY_CYC = 12
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic trig_i,
    output logic      fire_o
);
    localparam int CW = $clog2(DELAY_CYC + 1);
    localparam int DLY = DELAY_CYC;

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_fire;

    // A new edge restarts the wait, so a glitch pair closer than the delay yields one event.
    always_comb begin
        next_cnt = (cnt != '0) ? cnt - CW'(1) : cnt;
        if (trig_i) begin
            next_cnt = CW'(DELAY_CYC - 1); // [R17]
        end
        next_fire = (cnt == CW'(1)) & ~trig_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt    <= '0;
            fire_o <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            fire_o <= next_fire;
        end
    end

    a_fire_delay: assert property (@(posedge clk_i) disable iff (!rstn_i)
        fire_o |-> $past(trig_i, DLY)) // [R17]
        else $error("Event fired without an edge the set delay earlier.");
endmodule

// ===== cmp_pkg.sv
// Types and the address decoder shared by the comparator control block.
package cmp_pkg;
    `include "cmp_consts.svh"

    typedef enum logic [1:0] {REF_LADDER, REF_BANDGAP, REF_EXTERNAL} ref_source_t;
    typedef enum logic [1:0] {SEL_NONE, SEL_REF, SEL_CTRL} reg_sel_t;

    typedef struct packed {
        logic        power_on;
        logic        hyst_en;
        ref_source_t source;
        logic [3:0]  level_code;
    } analog_ctrl_t;

    typedef struct packed {
        logic [2:0] pos_channel;
        logic [2:0] neg_channel;
    } adc_tap_t;

    // Misaligned byte addresses never hit a register.
    function automatic reg_sel_t reg_decode(input logic [`AXI_ADDR_W-1:0] addr);
        reg_decode = SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[`AXI_ADDR_W-1:2] == `REF_SEL_INDEX) begin
            reg_decode = SEL_REF;
        end else if (addr[1:0] == 2'h0 && addr[`AXI_ADDR_W-1:2] == `CMP_CTRL_INDEX) begin
            reg_decode = SEL_CTRL;
        end
    endfunction
endpackage

// ===== cmp_sync.sv
// Two-stage synchroniser for the asynchronous comparator result.
`timescale 1ns/1ps
module cmp_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;

    // Only the last stage is visible; the first stage may be metastable.
    always_comb begin
        next_chain = {chain[STAGES-2:0], d_i}; // [R21]
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    assign q_o = chain[STAGES-1];
endmodule

// ===== comparator_ref_control.sv
// Register file, reference routing and event logic of the analog comparator, behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "cmp_consts.svh"
// How it works
// R1: External select routes external reference, overriding all.
// R2: Bandgap select drives fixed reference otherwise.
// R3: Level code picks one of sixteen ladder steps.
// R4: Software writes zeros to reserved bits.
// R5: Power bit enables comparator, reference, bias.
// R6: Powered off, comparator output reads one.
// R7: Output enable puts result on port pin.
// R8: Result always feeds timer break input.
// R9: Inversion bit inverts comparator output.
// R10: Inversion picks rising or falling event edge.
// R11: Selected edge sets the event flag.
// R12: Control read clears flag; writes ignore it.
// R13: Interrupt needs flag and enable both set.
// R14: Software enables interrupt after power stabilises.
// R15: Hysteresis bit, reset set, control resets 80h.
// R16: Result bit mirrors output, reset cleared.
// R17: Event reaches flag about 250ns later.
// R18: Input pins also feed ADC channels.
// R19: Reference select resets to zero.
// R20: Output one when positive exceeds negative.
// R21: Comparator result synchronised by two flops.
// R22: Edge in read cycle keeps flag set.
module comparator_ref_control #(
    parameter int EDGE_DELAY_CYC = `EDGE_DELAY_CYC
) (
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     s_axi_awvalid_i,
    output logic                          s_axi_awready_o,
    input  wire logic [`AXI_ADDR_W-1:0]   s_axi_awaddr_i,
    input  wire logic                     s_axi_wvalid_i,
    output logic                          s_axi_wready_o,
    input  wire logic [31:0]              s_axi_wdata_i,
    input  wire logic [3:0]               s_axi_wstrb_i,
    output logic                          s_axi_bvalid_o,
    input  wire logic                     s_axi_bready_i,
    output logic [1:0]                    s_axi_bresp_o,
    input  wire logic                     s_axi_arvalid_i,
    output logic                          s_axi_arready_o,
    input  wire logic [`AXI_ADDR_W-1:0]   s_axi_araddr_i,
    output logic                          s_axi_rvalid_o,
    input  wire logic                     s_axi_rready_i,
    output logic [31:0]                   s_axi_rdata_o,
    output logic [1:0]                    s_axi_rresp_o,
    input  wire logic                     cmp_raw_i,
    output cmp_pkg::analog_ctrl_t         analog_ctrl_o,
    output cmp_pkg::adc_tap_t             adc_tap_o,
    output logic                          break_o,
    output logic                          cmp_pin_o,
    output logic                          cmp_pin_oe_o,
    output logic                          irq_o
);
    import cmp_pkg::*;

    // Bus holding state.
    logic                   aw_full;
    logic                   w_full;
    logic [`AXI_ADDR_W-1:0] aw_addr;
    logic [7:0]             w_data;
    logic                   w_lane0;
    logic                   next_aw_full;
    logic                   next_w_full;
    logic [`AXI_ADDR_W-1:0] next_aw_addr;
    logic [7:0]             next_w_data;
    logic                   next_w_lane0;
    logic                   next_bvalid;
    logic [1:0]             next_bresp;
    logic                   next_rvalid;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;

    // Register and output state.
    logic [7:0]    ref_sel;
    logic          hyst;
    logic          inv;
    logic          flag;
    logic          ien;
    logic          result;
    logic          poe;
    logic          pon;
    logic          raw_prev;
    logic [7:0]    next_ref_sel;
    logic          next_hyst;
    logic          next_inv;
    logic          next_flag;
    logic          next_ien;
    logic          next_result;
    logic          next_poe;
    logic          next_pon;
    logic          next_raw_prev;
    logic          next_break;
    logic          next_irq;
    analog_ctrl_t  next_actrl;

    // Handshake and event terms.
    logic          aw_take;
    logic          w_take;
    logic          ar_take;
    logic          wr_commit;
    reg_sel_t      wr_sel;
    reg_sel_t      rd_sel;
    logic          raw_sync;
    logic          final_out;
    logic          cmp_edge;
    logic          ev_fire;
    logic [7:0]    ctrl_view;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // The raw result is asynchronous to the bus clock.
    cmp_sync #(
        .STAGES (2)
    ) u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    (cmp_raw_i),
        .q_o    (raw_sync)
    );

    cmp_event_delay #(
        .DELAY_CYC (EDGE_DELAY_CYC)
    ) u_delay (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .trig_i (cmp_edge),
        .fire_o (ev_fire)
    );

    // Bus handshakes; a write commits in the first cycle that both address and data are held and no response is pending.
    assign aw_take   = s_axi_awvalid_i & s_axi_awready_o;
    assign w_take    = s_axi_wvalid_i & s_axi_wready_o;
    assign ar_take   = s_axi_arvalid_i & s_axi_arready_o;
    assign wr_commit = aw_full & w_full & ~s_axi_bvalid_o;
    assign wr_sel    = reg_decode(aw_addr);
    assign rd_sel    = reg_decode(s_axi_araddr_i);

    // Powered off, the output sits at one; otherwise the synchronised result, optionally inverted.
    assign final_out = pon ? (raw_sync ^ inv) : 1'b1; // [R6] [R9] [R20]
    assign cmp_edge  = pon & (inv ? (raw_prev & ~raw_sync) : (~raw_prev & raw_sync)); // [R10]
    assign ctrl_view = {hyst, 1'b0, inv, flag, ien, result, poe, pon};

    // Next state of the bus slave.
    always_comb begin
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid  = s_axi_bvalid_o;
        next_bresp   = s_axi_bresp_o;
        next_rvalid  = s_axi_rvalid_o;
        next_rdata   = s_axi_rdata_o;
        next_rresp   = s_axi_rresp_o;
        if (aw_take) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (w_take) begin
            next_w_full  = 1'b1;
            next_w_data  = s_axi_wdata_i[7:0];
            next_w_lane0 = s_axi_wstrb_i[0];
        end
        if (wr_commit) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            case (rd_sel)
                SEL_REF: begin
                    next_rdata = {24'h0, ref_sel};
                end
                SEL_CTRL: begin
                    next_rdata = {24'h0, ctrl_view};
                end
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_full         <= 1'b0;
            w_full          <= 1'b0;
            aw_addr         <= '0;
            w_data          <= 8'h00;
            w_lane0         <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_arready_o <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= `RESP_OKAY;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0;
            s_axi_rresp_o   <= `RESP_OKAY;
        end else begin
            aw_full         <= next_aw_full;
            w_full          <= next_w_full;
            aw_addr         <= next_aw_addr;
            w_data          <= next_w_data;
            w_lane0         <= next_w_lane0;
            s_axi_awready_o <= ~next_aw_full;
            s_axi_wready_o  <= ~next_w_full;
            s_axi_arready_o <= ~next_rvalid;
            s_axi_bvalid_o  <= next_bvalid;
            s_axi_bresp_o   <= next_bresp;
            s_axi_rvalid_o  <= next_rvalid;
            s_axi_rdata_o   <= next_rdata;
            s_axi_rresp_o   <= next_rresp;
        end
    end

    // Next state of the registers and of the analog control output; the ADC tap is loaded with constants in the register stage.
    always_comb begin
        next_ref_sel  = ref_sel;
        next_hyst     = hyst;
        next_inv      = inv;
        next_flag     = flag;
        next_ien      = ien;
        next_poe      = poe;
        next_pon      = pon;
        next_raw_prev = raw_sync;
        next_result   = final_out; // [R16]
        next_break    = final_out; // [R8]
        next_irq      = flag & ien; // [R13]
        if (wr_commit && w_lane0 && wr_sel == SEL_REF) begin
            // Reserved low bits are forced to zero whatever software writes.
            next_ref_sel = {w_data[7:2], 2'h0}; // [R4]
        end
        if (wr_commit && w_lane0 && wr_sel == SEL_CTRL) begin
            // The flag and result bits are not writable; bit 6 is dropped.
            next_hyst = w_data[`CC_HYST_BIT]; // [R15]
            next_inv  = w_data[`CC_INV_BIT]; // [R9]
            next_ien  = w_data[`CC_IEN_BIT]; // [R13]
            next_poe  = w_data[`CC_POE_BIT]; // [R7]
            next_pon  = w_data[`CC_PON_BIT]; // [R5]
        end
        if (ar_take && rd_sel == SEL_CTRL) begin
            next_flag = 1'b0; // [R12]
        end
        // The set comes last so an event in a read cycle is never lost.
        if (ev_fire) begin
            next_flag = 1'b1; // [R11] [R22]
        end
        next_actrl.power_on   = pon; // [R5]
        next_actrl.hyst_en    = hyst; // [R15]
        next_actrl.level_code = ref_sel[`RS_LVL_HI:`RS_LVL_LO]; // [R3]
        if (ref_sel[`RS_EXT_BIT]) begin
            next_actrl.source = REF_EXTERNAL; // [R1]
        end else if (ref_sel[`RS_BGR_BIT]) begin
            next_actrl.source = REF_BANDGAP; // [R2]
        end else begin
            next_actrl.source = REF_LADDER; // [R3]
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_sel       <= `REF_SEL_RESET; // [R19]
            hyst          <= 1'((`CMP_CTRL_RESET) >> `CC_HYST_BIT); // [R15]
            inv           <= 1'b0;
            flag          <= 1'b0;
            ien           <= 1'b0;
            result        <= 1'b0;
            poe           <= 1'b0;
            pon           <= 1'b0;
            raw_prev      <= 1'b0;
            break_o       <= 1'b1;
            cmp_pin_o     <= 1'b1;
            cmp_pin_oe_o  <= 1'b0;
            irq_o         <= 1'b0;
            analog_ctrl_o <= '{power_on: 1'b0, hyst_en: 1'b1, source: REF_LADDER, level_code: 4'h0};
            adc_tap_o     <= '{pos_channel: `ADC_CH_POS, neg_channel: `ADC_CH_NEG}; // [R18]
        end else begin
            ref_sel       <= next_ref_sel;
            hyst          <= next_hyst;
            inv           <= next_inv;
            flag          <= next_flag;
            ien           <= next_ien;
            result        <= next_result;
            poe           <= next_poe;
            pon           <= next_pon;
            raw_prev      <= next_raw_prev;
            break_o       <= next_break;
            cmp_pin_o     <= next_break;
            cmp_pin_oe_o  <= poe; // [R7]
            irq_o         <= next_irq;
            analog_ctrl_o <= next_actrl;
            adc_tap_o     <= '{pos_channel: `ADC_CH_POS, neg_channel: `ADC_CH_NEG};
        end
    end

    // Edge qualification in one cycle: power and inversion state together with the result's change.
    sequence s_rise_event;
        pon && !inv && $rose(raw_sync);
    endsequence

    sequence s_fall_event;
        pon && inv && $fell(raw_sync);
    endsequence

    a_ext_ref_wins: assert property (ref_sel[`RS_EXT_BIT] |=> analog_ctrl_o.source == REF_EXTERNAL) // [R1]
        else $error("External select did not route the external reference.");

    a_bandgap_route: assert property (!ref_sel[`RS_EXT_BIT] && ref_sel[`RS_BGR_BIT]
        |=> analog_ctrl_o.source == REF_BANDGAP) // [R2]
        else $error("Bandgap select did not route the bandgap.");

    a_ladder_code: assert property (!ref_sel[`RS_EXT_BIT] && !ref_sel[`RS_BGR_BIT]
        |=> analog_ctrl_o.source == REF_LADDER && analog_ctrl_o.level_code == $past(ref_sel[5:2])) // [R3]
        else $error("Ladder level does not follow the level code.");

    a_off_reads_one: assert property (!pon ##1 !pon |=> break_o && result) // [R6]
        else $error("Powered-off comparator output is not one.");

    a_pin_gate: assert property (##1 cmp_pin_oe_o == $past(poe) && cmp_pin_o == break_o) // [R7]
        else $error("Port pin does not follow the output enable.");

    a_edge_select: assert property ((s_rise_event or s_fall_event) |-> cmp_edge) // [R10]
        else $error("Selected comparator edge was not detected.");

    a_no_wrong_edge: assert property (cmp_edge |-> pon && (inv ? $fell(raw_sync) : $rose(raw_sync))) // [R10]
        else $error("Edge detected on the wrong polarity.");

    a_flag_sets: assert property (ev_fire |=> flag) // [R11] [R22]
        else $error("Event did not set the flag.");

    a_read_clears: assert property (ar_take && rd_sel == SEL_CTRL && !ev_fire |=> !flag) // [R12]
        else $error("Control read did not clear the flag.");

    a_write_keeps: assert property (wr_commit && wr_sel == SEL_CTRL && !ev_fire && !ar_take
        |=> flag == $past(flag)) // [R12]
        else $error("Control write changed the flag.");

    a_irq_gate: assert property (flag && ien ##1 flag && ien |-> irq_o) // [R13]
        else $error("Interrupt missing with flag and enable set.");

    a_irq_quiet: assert property (!ien ##1 !ien |-> !irq_o) // [R13]
        else $error("Interrupt raised while disabled.");

    a_write_answer: assert property (wr_commit |=> s_axi_bvalid_o && !aw_full)
        else $error("Write commit gave no response.");
endmodule

// ===== tb_top.sv
// Self-checking bench for the comparator control block over its AXI4-Lite port.
`timescale 1ns/1ps
`include "cmp_consts.svh"
module tb_top;
    import cmp_pkg::*;
    localparam logic [7:0] REF_A = {`REF_SEL_INDEX, 2'b00};
    localparam logic [7:0] CTL_A = {`CMP_CTRL_INDEX, 2'b00};
    logic         clk_i           = 1'b0;
    logic         rstn_i          = 1'b0;
    logic         s_axi_awvalid_i = 1'b0;
    logic         s_axi_wvalid_i  = 1'b0;
    logic         s_axi_bready_i  = 1'b0;
    logic         s_axi_arvalid_i = 1'b0;
    logic         s_axi_rready_i  = 1'b0;
    logic [7:0]   s_axi_awaddr_i  = 8'h00;
    logic [7:0]   s_axi_araddr_i  = 8'h00;
    logic [31:0]  s_axi_wdata_i   = 32'h0;
    logic [3:0]   s_axi_wstrb_i   = 4'h1;
    logic         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]   s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0]  s_axi_rdata_o;
    logic         cmp_raw, break_o, cmp_pin_o, cmp_pin_oe_o, irq_o;
    analog_ctrl_t analog_ctrl_o;
    adc_tap_t     adc_tap_o;
    int           pos_mv          = 500;
    int           errors          = 0;
    int           check_count     = 0;
    int           cycles          = 0;
    int           n;

    always #10 clk_i = ~clk_i;

    comparator_ref_control #(.EDGE_DELAY_CYC(12)) dut_u (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_awaddr_i(s_axi_awaddr_i),
        .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
        .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .cmp_raw_i(cmp_raw),
        .analog_ctrl_o(analog_ctrl_o), .adc_tap_o(adc_tap_o), .break_o(break_o), .cmp_pin_o(cmp_pin_o),
        .cmp_pin_oe_o(cmp_pin_oe_o), .irq_o(irq_o)
    );

    cmp_analog_model model_u (
        .ctrl_i(analog_ctrl_o), .pos_mv_i(pos_mv), .ext_mv_i(2000), .raw_o(cmp_raw)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write: address and data offered together, each dropped once taken, then the response.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic [1:0] resp);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk_i);
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_awaddr_i  <= addr;
        s_axi_wdata_i   <= {24'h0, data};
        s_axi_bready_i  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_i);
            if (!aw && s_axi_awready_o === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (!w && s_axi_wready_o === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        check(32'(s_axi_bresp_o), 32'(resp));
        // The analog controls are registered once more after the commit, so let that edge pass.
        @(posedge clk_i);
    endtask

    // Read: the data and the response code are taken at the edge that sees rvalid.
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic [1:0] resp);
        @(posedge clk_i);
        s_axi_arvalid_i <= 1'b1;
        s_axi_araddr_i  <= addr;
        s_axi_rready_i  <= 1'b1;
        do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        check(s_axi_rdata_o, {24'h0, exp});
        check(32'(s_axi_rresp_o), 32'(resp));
    endtask

    // Moves the positive input; long settle covers sync, event delay and comparator start-up.
    task automatic set_pos(input int mv);
        @(posedge clk_i);
        pos_mv <= mv;
    endtask

    task automatic settle();
        repeat (30) @(posedge clk_i);
    endtask

    task automatic wait_irq(output int cnt);
        cnt = 0;
        while (irq_o !== 1'b1 && cnt < 40) begin
            @(posedge clk_i);
            cnt++;
        end
    endtask

    // A hang is cut short well beyond the few hundred cycles the sequence needs.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(REF_A, 8'h00, `RESP_OKAY);
        rd(CTL_A, 8'h84, `RESP_OKAY);
        check(32'(break_o), 32'h1);
        check(32'(cmp_pin_oe_o), 32'h0);
        check(32'(adc_tap_o), 32'h04);
        check(32'(analog_ctrl_o), 32'h40);
        for (int c = 0; c < 16; c++) begin
            wr(REF_A, 8'(c << 2) | 8'h03, `RESP_OKAY);
            rd(REF_A, 8'(c << 2), `RESP_OKAY);
            check(32'(analog_ctrl_o), 32'h40 | 32'(c));
        end
        wr(REF_A, 8'h7c, `RESP_OKAY);
        check(32'(analog_ctrl_o.source), 32'(REF_BANDGAP));
        wr(REF_A, 8'hbc, `RESP_OKAY);
        check(32'(analog_ctrl_o.source), 32'(REF_EXTERNAL));
        wr(REF_A, 8'hfc, `RESP_OKAY);
        check(32'(analog_ctrl_o.source), 32'(REF_EXTERNAL));
        // Ladder at 1.0 V; power-on with the input above it gives a rising result.
        wr(REF_A, 8'h10, `RESP_OKAY);
        set_pos(1500);
        wr(CTL_A, 8'h81, `RESP_OKAY);
        settle();
        check(32'(break_o), 32'h1);
        rd(CTL_A, 8'h95, `RESP_OKAY);
        set_pos(500);
        settle();
        check(32'(break_o), 32'h0);
        rd(CTL_A, 8'h81, `RESP_OKAY);
        wr(CTL_A, 8'h83, `RESP_OKAY);
        settle();
        check(32'(cmp_pin_oe_o), 32'h1);
        check(32'(cmp_pin_o), 32'h0);
        wr(CTL_A, 8'ha3, `RESP_OKAY);
        settle();
        check(32'(break_o), 32'h1);
        rd(CTL_A, 8'ha7, `RESP_OKAY);
        // Inverted mode: only a falling raw result raises the flag.
        wr(CTL_A, 8'ha9, `RESP_OKAY);
        set_pos(1500);
        settle();
        check(32'(irq_o), 32'h0);
        set_pos(500);
        wait_irq(n);
        check(32'(n >= 14 && n <= 20), 32'h1);
        check(32'(irq_o), 32'h1);
        rd(CTL_A, 8'hbd, `RESP_OKAY);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        wr(CTL_A, 8'hb9, `RESP_OKAY);
        rd(CTL_A, 8'had, `RESP_OKAY);
        // A flag held while masked raises the request once enabled.
        wr(CTL_A, 8'h81, `RESP_OKAY);
        set_pos(1500);
        settle();
        check(32'(irq_o), 32'h0);
        wr(CTL_A, 8'h89, `RESP_OKAY);
        repeat (3) @(posedge clk_i);
        check(32'(irq_o), 32'h1);
        rd(CTL_A, 8'h9d, `RESP_OKAY);
        set_pos(500);
        settle();
        wr(CTL_A, 8'h80, `RESP_OKAY);
        settle();
        check(32'(break_o), 32'h1);
        check(32'(analog_ctrl_o.power_on), 32'h0);
        wr(CTL_A, 8'h40, `RESP_OKAY);
        check(32'(analog_ctrl_o.hyst_en), 32'h0);
        rd(CTL_A, 8'h04, `RESP_OKAY);
        // A write with the low byte lane off is answered but changes nothing.
        s_axi_wstrb_i <= 4'h0;
        wr(REF_A, 8'hff, `RESP_OKAY);
        s_axi_wstrb_i <= 4'h1;
        wr(8'hb8, 8'hff, `RESP_SLVERR);
        rd(8'hb8, 8'h00, `RESP_SLVERR);
        rd(8'hb1, 8'h00, `RESP_SLVERR);
        rd(REF_A, 8'h10, `RESP_OKAY);
        give_verdict();
    end
endmodule
